//--- hw/flash_array_mem.sv
// flash array storage with registered read data and status bypass
`timescale 1ns/1ps
module flash_array_mem #(
  parameter int WAW = 17
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  mem_port_if.mem m
);
  logic [31:0] mem_q [2**WAW];

  // no reset on the array: contents are undefined until erased
  always_ff @(posedge clock_i) begin
    if (m.en && m.we) begin
      mem_q[m.addr] <= m.wdata;
    end
  end

  // bypass wins so a status read never reaches the array
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      m.rdata <= 32'h0000_0000;
    end else if (m.byp) begin
      m.rdata <= m.bdata;
    end else if (m.en && !m.we) begin
      m.rdata <= mem_q[m.addr];
    end
  end
endmodule

//--- hw/flash_cmd_seq.sv
// command sequencer in front of the on-chip flash array
//
// Operation
// [RL1] read mode, valid command enters embedded mode
// [RL2] no array data while embedded op runs
// [RL3] read mode after reset and success
// [RL4] abnormal end holds until reset command
// [RL5] reset command aborts partial sequence
// [RL6] invalid sequence clears, returns read mode
// [RL7] command bytes on low byte lanes
// [RL8] chip reset stops operation, read mode
// [RL9] program only clears bits to zero
// [RL10] program takes four cycles, data last
// [RL11] requester aligns program addresses to longwords
// [RL12] programming non-erased longwords is accepted
// [RL13] partial erased update keeps ones set
// [RL14] partial non-erased update: read, modify, write
// [RL15] 32K blocks; chip, block, multi-block erase
// [RL16] algorithm runs without requester timing
// [RL17] status bits show polling and toggle
// [RL18] security off erases everything, protected too
// [RL19] protected block refuses program and erase
// [RL20] commands bytewise, program data 32-bit
// [RL21] writes ignored during embedded operation
// [RL22] busy reads return the status word
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "flash_seq_params.svh"
module flash_cmd_seq
  import flash_seq_pkg::*;
#(
  parameter int AW = 19,
  parameter int NBLK = 16
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [NBLK-1:0] block_protect_i,
  input wire logic security_off_i,
  output logic [31:0] rdata_o,
  output logic busy_o,
  output logic fail_o
);
  localparam int WAW = AW - 2;
  localparam int NBW = AW - `BLK_SHIFT;
  localparam int BWB = `BLK_SHIFT - 2;
  localparam logic [NBW-1:0] BLK_ONE = NBW'(1);
  localparam logic [NBW-1:0] BLK_LAST = NBW'(NBLK - 1);
  localparam logic [WAW-1:0] W_ONE = WAW'(1);
  localparam logic [NBLK-1:0] HOT_ONE = NBLK'(1);

  // ****************************************
  // state
  // ****************************************
  seq_state_t st_q, st_d;
  logic [2:0] cyc_q, cyc_d;
  logic ers_q, ers_d;
  logic [NBLK-1:0] sel_q, sel_d;
  logic force_q, force_d;
  logic [WAW-1:0] widx_q, widx_d;
  logic [31:0] pdata_q, pdata_d;
  logic [11:0] tmr_q, tmr_d;
  logic tog_q, tog_d;
  logic busy_q;
  logic fail_q;

  logic [7:0] wr_byte;
  logic at_a1;
  logic at_a2;
  logic [NBW-1:0] addr_blk;
  logic [NBLK-1:0] addr_hot;
  logic [NBW-1:0] wblk;
  logic prg_state;
  logic [31:0] stat_w;

  mem_port_if #(.WAW(WAW)) m ();

  flash_array_mem #(.WAW(WAW)) u_array (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .m(m)
  );

  // only the low byte carries a command code
  assign wr_byte = wdata_i[7:0]; // [RL7]
  assign at_a1 = (addr_i[15:0] == `CMD_ADDR_1);
  assign at_a2 = (addr_i[15:0] == `CMD_ADDR_2);
  assign addr_blk = addr_i[AW-1:`BLK_SHIFT];
  assign addr_hot = HOT_ONE << addr_blk;
  assign wblk = widx_q[WAW-1:BWB];
  assign prg_state = (st_q == ST_PRG_RD) || (st_q == ST_PRG_WR) || (st_q == ST_PRG_VF) || (st_q == ST_PRG_CK);

  // ****************************************
  // status word
  // ****************************************
  always_comb begin
    stat_w = 32'h0000_0000;
    stat_w[`STAT_POLL_BIT] = prg_state ? ~pdata_q[7] : 1'b0; // [RL17]
    stat_w[`STAT_TOGGLE_BIT] = tog_q; // [RL17]
    stat_w[`STAT_FAIL_BIT] = (st_q == ST_FAIL);
    stat_w[`STAT_WINDOW_BIT] = (st_q != ST_ERS_WAIT);
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    st_d = st_q;
    cyc_d = cyc_q;
    ers_d = ers_q;
    sel_d = sel_q;
    force_d = force_q;
    widx_d = widx_q;
    pdata_d = pdata_q;
    tmr_d = tmr_q;
    tog_d = tog_q;
    m.en = 1'b0;
    m.we = 1'b0;
    m.byp = 1'b0;
    m.addr = addr_i[AW-1:2];
    m.wdata = wdata_i;
    m.bdata = stat_w;
    if (rd_i) begin
      if (st_q == ST_READ) begin
        m.en = 1'b1;
      end else begin
        m.byp = 1'b1; // [RL2] [RL22]
        tog_d = ~tog_q; // [RL17]
      end
    end
    unique case (st_q)
      ST_READ: begin
        if (security_off_i) begin
          // protection is overridden for the whole array
          sel_d = '1; // [RL18]
          force_d = 1'b1;
          widx_d = '0;
          cyc_d = 3'h0;
          ers_d = 1'b0;
          st_d = ST_ERS_WRITE;
        end else if (wr_i) begin
          // the program data cycle carries all 32 lanes, so 0xF0 there is data
          if (wr_byte == `CMD_RESET && !(cyc_q == 3'h3 && !ers_q)) begin
            cyc_d = 3'h0; // [RL5]
            ers_d = 1'b0;
          end else begin
            unique case (cyc_q)
              3'h0: cyc_d = (at_a1 && wr_byte == `CMD_UNLOCK_1) ? 3'h1 : 3'h0; // [RL6]
              3'h1: cyc_d = (at_a2 && wr_byte == `CMD_UNLOCK_2) ? 3'h2 : 3'h0; // [RL6]
              3'h2: begin
                cyc_d = 3'h0;
                if (at_a1 && wr_byte == `CMD_PROGRAM) begin
                  cyc_d = 3'h3;
                  ers_d = 1'b0;
                end else if (at_a1 && wr_byte == `CMD_ERASE) begin
                  cyc_d = 3'h3;
                  ers_d = 1'b1;
                end
              end
              3'h3: begin
                if (!ers_q) begin
                  // fourth cycle: full longword and its address
                  cyc_d = 3'h0;
                  widx_d = addr_i[AW-1:2]; // [RL10]
                  pdata_d = wdata_i; // [RL7] [RL10]
                  if (block_protect_i[addr_blk]) begin
                    tmr_d = 12'(`CYC_PROT_PRG); // [RL19]
                    st_d = ST_NOP;
                  end else begin
                    st_d = ST_PRG_RD; // [RL1]
                  end
                end else begin
                  cyc_d = (at_a1 && wr_byte == `CMD_UNLOCK_1) ? 3'h4 : 3'h0;
                end
              end
              3'h4: cyc_d = (at_a2 && wr_byte == `CMD_UNLOCK_2) ? 3'h5 : 3'h0;
              3'h5: begin
                cyc_d = 3'h0;
                ers_d = 1'b0;
                if (at_a1 && wr_byte == `CMD_CHIP) begin
                  widx_d = '0;
                  if (&block_protect_i) begin
                    tmr_d = 12'(`CYC_PROT_ERS); // [RL19]
                    st_d = ST_NOP;
                  end else begin
                    sel_d = '1; // [RL15]
                    st_d = ST_ERS_WRITE; // [RL1]
                  end
                end else if (wr_byte == `CMD_BLOCK) begin
                  sel_d = addr_hot; // [RL15]
                  tmr_d = 12'(`CYC_ERS_WINDOW);
                  st_d = ST_ERS_WAIT; // [RL1]
                end
              end
              default: cyc_d = 3'h0;
            endcase
          end
        end
      end
      ST_ERS_WAIT: begin
        // more blocks may join until the window closes
        if (wr_i) begin
          if (wr_byte == `CMD_BLOCK) begin
            sel_d = sel_q | addr_hot; // [RL15]
            tmr_d = 12'(`CYC_ERS_WINDOW);
          end else begin
            sel_d = '0; // [RL6]
            st_d = ST_READ;
          end
        end else if (tmr_q == 12'h000) begin
          widx_d = '0;
          if (|(sel_q & ~block_protect_i)) begin
            st_d = ST_ERS_WRITE;
          end else begin
            tmr_d = 12'(`CYC_PROT_ERS); // [RL19]
            st_d = ST_NOP;
          end
        end else begin
          tmr_d = tmr_q - 12'h001;
        end
      end
      ST_NOP: begin
        sel_d = '0;
        if (tmr_q == 12'h000) begin
          st_d = ST_READ;
        end else begin
          tmr_d = tmr_q - 12'h001;
        end
      end
      // a cpu read owns the port, so array reads wait for a free cycle
      ST_PRG_RD: begin
        if (!rd_i) begin
          m.en = 1'b1;
          m.addr = widx_q;
          st_d = ST_PRG_WR;
        end
      end
      ST_PRG_WR: begin
        // and-merge: ones in the data leave the cell unchanged
        m.en = 1'b1;
        m.we = 1'b1;
        m.addr = widx_q;
        m.wdata = m.rdata & pdata_q; // [RL9] [RL12]
        pdata_d = m.rdata & pdata_q;
        st_d = ST_PRG_VF; // [RL16]
      end
      ST_PRG_VF: begin
        if (!rd_i) begin
          m.en = 1'b1;
          m.addr = widx_q;
          st_d = ST_PRG_CK;
        end
      end
      ST_PRG_CK: begin
        st_d = (m.rdata == pdata_q) ? ST_READ : ST_FAIL; // [RL3] [RL16]
      end
      ST_ERS_WRITE: begin
        if (sel_q[wblk] && (!block_protect_i[wblk] || force_q)) begin
          m.en = 1'b1; // [RL19]
          m.we = 1'b1;
          m.addr = widx_q;
          m.wdata = `ERASED_WORD; // [RL9]
          st_d = ST_ERS_VF;
        end else if (wblk == BLK_LAST) begin
          sel_d = '0;
          force_d = 1'b0;
          st_d = ST_READ; // [RL3]
        end else begin
          widx_d = {wblk + BLK_ONE, {BWB{1'b0}}};
        end
      end
      ST_ERS_VF: begin
        if (!rd_i) begin
          m.en = 1'b1;
          m.addr = widx_q;
          st_d = ST_ERS_CK;
        end
      end
      ST_ERS_CK: begin
        if (m.rdata != `ERASED_WORD) begin
          st_d = ST_FAIL; // [RL16]
        end else if (&widx_q) begin
          sel_d = '0;
          force_d = 1'b0;
          st_d = ST_READ; // [RL3]
        end else begin
          widx_d = widx_q + W_ONE;
          st_d = ST_ERS_WRITE;
        end
      end
      ST_FAIL: begin
        if (wr_i && wr_byte == `CMD_RESET) begin
          sel_d = '0; // [RL4]
          force_d = 1'b0;
          st_d = ST_READ;
        end
      end
    endcase
  end

  // writes outside read mode act only in the erase window (block code adds a block, any other code aborts) and as the reset code in the fail state
  // chip reset is the flash reset: any operation is dropped at once
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= ST_READ; // [RL8] [RL3]
      cyc_q <= 3'h0;
      ers_q <= 1'b0;
      sel_q <= '0;
      force_q <= 1'b0;
      widx_q <= '0;
      pdata_q <= 32'h0000_0000;
      tmr_q <= 12'h000;
      tog_q <= 1'b0;
      busy_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cyc_q <= cyc_d;
      ers_q <= ers_d;
      sel_q <= sel_d;
      force_q <= force_d;
      widx_q <= widx_d;
      pdata_q <= pdata_d;
      tmr_q <= tmr_d;
      tog_q <= tog_d;
      busy_q <= (st_d != ST_READ); // [RL21]
      fail_q <= (st_d == ST_FAIL);
    end
  end

  assign rdata_o = m.rdata;
  assign busy_o = busy_q;
  assign fail_o = fail_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  busy_status_read_a: assert property ( // [RL2]
    (rd_i && st_q != ST_READ) |=> (rdata_o == $past(stat_w)))
    else $error("busy read did not return status word");
  toggle_flip_a: assert property ( // [RL17]
    (rd_i && st_q != ST_READ) ##1 (rd_i && st_q != ST_READ) |=>
      (rdata_o[`STAT_TOGGLE_BIT] != $past(rdata_o[`STAT_TOGGLE_BIT])))
    else $error("toggle bit did not flip");
  fail_hold_a: assert property ( // [RL4]
    (st_q == ST_FAIL && !(wr_i && wr_byte == `CMD_RESET)) |=> (st_q == ST_FAIL && fail_o))
    else $error("left fail state without reset command");
  sw_abort_a: assert property ( // [RL5]
    (st_q == ST_READ && !security_off_i && wr_i && wr_byte == `CMD_RESET && !(cyc_q == 3'h3 && !ers_q))
      |=> (cyc_q == 3'h0 && !busy_o))
    else $error("reset command did not clear sequence");
  bad_second_a: assert property ( // [RL6]
    (st_q == ST_READ && !security_off_i && cyc_q == 3'h1 && wr_i && !(at_a2 && wr_byte == `CMD_UNLOCK_2))
      |=> (cyc_q == 3'h0 && st_q == ST_READ))
    else $error("invalid second cycle not discarded");
  clear_only_a: assert property ( // [RL9]
    (m.we && prg_state) |-> ((m.wdata & ~m.rdata) == 32'h0000_0000))
    else $error("program raised a bit");
  prog_start_a: assert property ( // [RL10]
    (st_q == ST_READ && !security_off_i && cyc_q == 3'h3 && !ers_q && wr_i
      && !block_protect_i[addr_blk]) |=> (st_q == ST_PRG_RD && pdata_q == $past(wdata_i) ##1 busy_o))
    else $error("program did not start after fourth cycle");
  prog_done_a: assert property ( // [RL3]
    (st_q == ST_PRG_CK && m.rdata == pdata_q) |=> (st_q == ST_READ ##1 !busy_o))
    else $error("no return to read mode after program");
  protect_hold_a: assert property ( // [RL19]
    (m.we && st_q == ST_ERS_WRITE) |-> (!block_protect_i[wblk] || force_q))
    else $error("protected block erased");
  write_ignored_a: assert property ( // [RL21]
    (prg_state && wr_i) |=> (cyc_q == $past(cyc_q) && sel_q == $past(sel_q)))
    else $error("write during program changed command state");
  prot_prog_nop_a: assert property ( // [RL19]
    (st_q == ST_NOP) |-> !m.we)
    else $error("refused operation wrote the array");

  prog_pass_c: cover property (st_q == ST_PRG_CK ##1 st_q == ST_READ);
  multi_block_c: cover property (st_q == ST_ERS_WAIT && wr_i && wr_byte == `CMD_BLOCK);
  seq_abort_c: cover property (st_q == ST_READ && cyc_q == 3'h2 && wr_i && wr_byte == `CMD_RESET);
  secure_erase_c: cover property (st_q == ST_ERS_WRITE && force_q && m.we);
endmodule

//--- shared/flash_seq_params.svh
// constants of the on-chip flash command sequencer
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 40
`define T_PROT_PRG_NS 3000
`define T_PROT_ERS_NS 100000
`define T_ERS_WINDOW_NS 50000
`define CYC_PROT_PRG (`T_PROT_PRG_NS / `CLK_PERIOD_NS)
`define CYC_PROT_ERS (`T_PROT_ERS_NS / `CLK_PERIOD_NS)
`define CYC_ERS_WINDOW (`T_ERS_WINDOW_NS / `CLK_PERIOD_NS)

// ****************************************
// command addresses and codes
// ****************************************
`define CMD_ADDR_1 16'h5554
`define CMD_ADDR_2 16'hAAA8
`define CMD_UNLOCK_1 8'hAA
`define CMD_UNLOCK_2 8'h55
`define CMD_PROGRAM 8'hA0
`define CMD_ERASE 8'h80
`define CMD_CHIP 8'h10
`define CMD_BLOCK 8'h30
`define CMD_RESET 8'hF0

// ****************************************
// status word and array layout
// ****************************************
`define STAT_POLL_BIT 7
`define STAT_TOGGLE_BIT 6
`define STAT_FAIL_BIT 5
`define STAT_WINDOW_BIT 3
`define ERASED_WORD 32'hFFFF_FFFF
`define BLK_SHIFT 15

`endif

//--- shared/flash_seq_pkg.sv
// types of the on-chip flash command sequencer
package flash_seq_pkg;
  typedef enum logic [3:0] {
    ST_READ,
    ST_NOP,
    ST_PRG_RD,
    ST_PRG_WR,
    ST_PRG_VF,
    ST_PRG_CK,
    ST_ERS_WAIT,
    ST_ERS_WRITE,
    ST_ERS_VF,
    ST_ERS_CK,
    ST_FAIL
  } seq_state_t;
endpackage

//--- shared/mem_port_if.sv
// port between the sequencer and the flash array memory
`timescale 1ns/1ps
interface mem_port_if #(
  parameter int WAW = 17
);
  logic en;
  logic we;
  logic byp;
  logic [WAW-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] bdata;
  logic [31:0] rdata;
  modport seq (output en, output we, output byp, output addr, output wdata, output bdata, input rdata);
  modport mem (input en, input we, input byp, input addr, input wdata, input bdata, output rdata);
endinterface

//--- tb/cpu_bus_model.sv
// bus master model standing in for the on-chip cpu
`timescale 1ns/1ps
module cpu_bus_model #(
  parameter int AW = 17
) (
  input wire logic clock_i,
  output logic [AW-1:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    addr_o = '0;
    wdata_o = '0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // one write cycle; program addresses go out longword aligned
  task automatic wr_cyc(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_o <= {a[AW-1:2], 2'b00};
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
    // released lines show junk, not the last value
    addr_o <= ~addr_o;
    wdata_o <= ~wdata_o;
  endtask

  // command byte on the low lanes only, upper lanes zero
  task automatic cmd_cyc(input logic [AW-1:0] a, input logic [7:0] b);
    wr_cyc(a, {24'h00_0000, b});
  endtask

  // two reads with no gap: the strobe stays up across two edges
  task automatic rd_pair(input logic [AW-1:0] a);
    @(posedge clock_i);
    addr_o <= a;
    rd_o <= 1'b1;
    repeat (2) @(posedge clock_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
  endtask

  task automatic rd_cyc(input logic [AW-1:0] a);
    @(posedge clock_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
  endtask
endmodule

//--- tb/tb.sv
// self-checking bench of the flash command sequencer
`timescale 1ns/1ps
`include "flash_seq_params.svh"
module tb;
  typedef struct {
    logic [31:0] val;
    logic [31:0] mask;
  } note_t;
  localparam logic [16:0] A1 = {1'b0, `CMD_ADDR_1};
  localparam logic [16:0] A2 = {1'b0, `CMD_ADDR_2};
  localparam logic [16:0] WA = 17'h0_0100;
  logic clock_i;
  logic rst_n_i;
  logic [16:0] addr_i;
  logic [31:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [3:0] block_protect_i;
  logic security_off_i;
  logic [31:0] rdata_o;
  logic busy_o;
  logic fail_o;
  note_t exp_q[$];
  note_t mon_n;
  logic rd_pend;
  int fails;
  int samples_checked;
  int cyc;
  logic [31:0] d1;
  logic [31:0] d2;

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  cpu_bus_model #(.AW(17)) cpu (.clock_i(clock_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));

  // small AW keeps a block erase near 25k cycles
  flash_cmd_seq #(.AW(17), .NBLK(4)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .block_protect_i(block_protect_i),
    .security_off_i(security_off_i), .rdata_o(rdata_o), .busy_o(busy_o), .fail_o(fail_o));

  // ****************************************
  // checking
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want, input logic [31:0] mask);
    samples_checked++;
    if ((seen & mask) !== (want & mask)) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, want & mask, seen & mask);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // read data is registered: it stands from the cycle after the strobe until the next read
  always @(negedge clock_i) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) begin
        chk("read_note", 32'h0000_0000, 32'h0000_0001, 32'h0000_0001);
      end else begin
        mon_n = exp_q.pop_front();
        chk("rdata", rdata_o, mon_n.val, mon_n.mask);
      end
    end
    rd_pend = rd_i;
  end

  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 45000) begin
      fails++;
      complete_run();
    end
  end

  // ****************************************
  // bus sequences
  // ****************************************
  task automatic cmd(input logic [16:0] a, input logic [7:0] b);
    cpu.cmd_cyc(a, b);
  endtask

  task automatic unlock();
    cmd(A1, `CMD_UNLOCK_1);
    cmd(A2, `CMD_UNLOCK_2);
  endtask

  task automatic prog(input logic [16:0] a, input logic [31:0] d);
    unlock();
    cmd(A1, `CMD_PROGRAM);
    cpu.wr_cyc(a, d);
  endtask

  task automatic erase6(input logic [16:0] a, input logic [7:0] b);
    unlock();
    cmd(A1, `CMD_ERASE);
    unlock();
    cmd(a, b);
  endtask

  task automatic rd(input logic [16:0] a, input logic [31:0] v, input logic [31:0] m);
    exp_q.push_back('{v, m});
    cpu.rd_cyc(a);
  endtask

  task automatic chk_busy(input logic want);
    repeat (2) @(posedge clock_i);
    #1;
    chk("busy", {31'h0000_0000, busy_o}, {31'h0000_0000, want}, 32'h0000_0001);
  endtask

  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < lim) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chk("busy_end", {31'h0000_0000, busy_o}, 32'h0000_0000, 32'h0000_0001);
    chk("fail", {31'h0000_0000, fail_o}, 32'h0000_0000, 32'h0000_0001);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    rst_n_i = 1'b0;
    security_off_i = 1'b0;
    block_protect_i = 4'h0;
    rd_pend = 1'b0;
    fails = 0;
    samples_checked = 0;
    cyc = 0;
    void'($urandom(77473));
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    chk_busy(1'b0);
    $display("test reset done");
    block_protect_i <= 4'h2;
    erase6(17'h0_0000, `CMD_BLOCK);
    // second block joins the window but is protected, so it is skipped
    cmd(17'h0_8000, `CMD_BLOCK);
    // toggle starts at zero after reset and flips on every busy read
    exp_q.push_back('{32'h0000_0000, 32'hFFFF_FFFF});
    exp_q.push_back('{32'h0000_0040, 32'hFFFF_FFFF});
    cpu.rd_pair(WA);
    repeat (1298) @(posedge clock_i);
    chk_busy(1'b1);
    rd(WA, 32'h0000_0008, 32'hFFFF_FFFF);
    wait_idle(30000);
    rd(WA, `ERASED_WORD, 32'hFFFF_FFFF);
    $display("test block erase done");
    d1 = $urandom();
    d2 = $urandom();
    // a data low byte equal to the reset code must still program
    d2[7:0] = 8'hF0;
    prog(WA, d1);
    // lands while the program runs and must change nothing
    cpu.wr_cyc(WA, 32'h0000_0000);
    wait_idle(20);
    rd(WA, d1, 32'hFFFF_FFFF);
    prog(WA, d2);
    rd(WA, {24'h00_0000, ~d2[7], 7'h48}, 32'hFFFF_FFFF);
    wait_idle(20);
    rd(WA, d1 & d2, 32'hFFFF_FFFF);
    $display("test program done");
    for (int k = 0; k < 2; k++) begin
      unlock();
      cmd(A1, (k == 0) ? `CMD_RESET : 8'h77);
      cmd(A1, `CMD_PROGRAM);
      cpu.wr_cyc(WA, 32'h0000_0000);
      chk_busy(1'b0);
    end
    rd(WA, d1 & d2, 32'hFFFF_FFFF);
    $display("test abort done");
    block_protect_i <= 4'h4;
    prog(17'h1_0100, $urandom());
    repeat (38) @(posedge clock_i);
    chk_busy(1'b1);
    wait_idle(100);
    block_protect_i <= 4'hF;
    erase6(A1, `CMD_CHIP);
    chk_busy(1'b1);
    wait_idle(2600);
    rd(WA, d1 & d2, 32'hFFFF_FFFF);
    $display("test protection done");
    @(posedge clock_i);
    security_off_i <= 1'b1;
    @(posedge clock_i);
    security_off_i <= 1'b0;
    repeat (2998) @(posedge clock_i);
    chk_busy(1'b1);
    rst_n_i <= 1'b0;
    #1;
    chk("busy_in_reset", {31'h0000_0000, busy_o}, 32'h0000_0000, 32'h0000_0001);
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    chk_busy(1'b0);
    $display("test security and reset done");
    repeat (3) @(posedge clock_i);
    complete_run();
  end
endmodule
